// ### hdl/mief_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module mief_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mief_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mief_pkg::mief_events_s events,
  output logic core_irq_req,
  output logic irq
);
  // register file
  logic [7:0] core_irq_control; // enables plus three flags
  logic [7:0] peripheral_irq_enable; // implemented bits only
  logic [7:0] peripheral_irq_flags; // peripheral flags
  logic [6:0] irq_status; // sticky event copies
  logic [6:0] irq_mask; // event interrupt mask
  logic [7:0] core_flags_q; // flag reg instance output
  logic [7:0] core_en_q; // enable half of core control

  mief_pkg::mief_apb_req_s req; // bundled apb request
  logic wr_stb; // access-phase write strobe
  logic rd_stb; // access-phase read strobe
  logic [31:0] rd_word; // selected read value
  logic rd_hit; // address maps to a register
  logic lane0; // low byte lane written
  logic [7:0] wbyte; // low byte of write data

  // field masks derived from the package positions, so the enable
  // and flag halves of core control can never overlap by a typo
  localparam logic [7:0] CC_EN_BITS = 8'(
    (1 << mief_pkg::CC_GIE) | (1 << mief_pkg::CC_PERIPHERAL_GROUP_ENABLE) |
    (1 << mief_pkg::CC_T0IE) | (1 << mief_pkg::CC_EXTIE) |
    (1 << mief_pkg::CC_PCIE));
  localparam logic [7:0] CC_FLAG_BITS = 8'(
    (1 << mief_pkg::CC_T0IF) | (1 << mief_pkg::CC_EXTIF) |
    (1 << mief_pkg::CC_PCIF));

  // a core source is armed when its enable and its flag are both set
  function automatic logic armed(
    input logic [7:0] ctrl,
    input int en_pos,
    input int flag_pos
  );
    armed = ctrl[en_pos] & ctrl[flag_pos];
  endfunction

  // printed offsets are word indices, the bus sees four times them
  // index to byte address
  function automatic logic [mief_pkg::ADDR_W-1:0] byte_addr(
    input logic [7:0] idx
  );
    byte_addr = mief_pkg::ADDR_W'({idx, 2'b00});
  endfunction

  // decode: does the bus address hit a given index
  function automatic logic hit(
    input logic [mief_pkg::ADDR_W-1:0] a,
    input logic [7:0] idx
  );
    hit = (a == byte_addr(idx));
  endfunction

  // bundle the request with one driver so no field is left floating
  assign req = '{
    sel: psel,
    enable: penable,
    write: pwrite,
    addr: paddr,
    wdata: pwdata
  };
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  // register selects, both core control aliases share storage
  // one select for both banks, so either alias lands in the same flops
  logic sel_cc; // core control, either bank
  logic sel_pe; // peripheral enable
  logic sel_pf; // peripheral flags
  logic sel_st; // event status
  logic sel_mk; // event mask

  assign sel_cc = hit(paddr, mief_pkg::CORE_CTRL_IDX_LO) |
                  hit(paddr, mief_pkg::CORE_CTRL_IDX_HI);
  assign sel_pe = hit(paddr, mief_pkg::PERIPH_EN_IDX);
  assign sel_pf = hit(paddr, mief_pkg::PERIPH_FLAG_IDX);
  assign sel_st = hit(paddr, mief_pkg::IRQ_STATUS_IDX);
  assign sel_mk = hit(paddr, mief_pkg::IRQ_MASK_IDX);
  assign rd_hit = sel_cc | sel_pe | sel_pf | sel_st | sel_mk;

  // unmapped addresses fall through to zero
  // read mux, narrow registers sit in the low bits
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_cc) begin
      rd_word[7:0] = core_irq_control;
    end else if (sel_pe) begin
      rd_word[7:0] = peripheral_irq_enable;
    end else if (sel_pf) begin
      rd_word[7:0] = peripheral_irq_flags;
    end else if (sel_st) begin
      rd_word[6:0] = irq_status;
    end else if (sel_mk) begin
      rd_word[6:0] = irq_mask;
    end
  end

  // bus front: zero wait states, read data taken in the setup cycle
  mief_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .rd_word(rd_word),
    .rd_hit(rd_hit),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // per-register write enables, only when the low lane is strobed
  // upper lanes carry no register bits, so they are ignored
  logic wr_cc; // core control write
  logic wr_pe; // peripheral enable write
  logic wr_pf; // peripheral flag write
  logic wr_st; // status write-one-clear
  logic wr_mk; // mask write
  assign wr_cc = wr_stb & lane0 & sel_cc;
  assign wr_pe = wr_stb & lane0 & sel_pe;
  assign wr_pf = wr_stb & lane0 & sel_pf;
  assign wr_st = wr_stb & lane0 & sel_st;
  assign wr_mk = wr_stb & lane0 & sel_mk;

  // core flag set pulses in their bit positions
  // pulse or level: every cycle high sets the flag again
  logic [7:0] core_set; // timer zero, edge pin, port change
  always_comb begin
    core_set = 8'h00;
    core_set[mief_pkg::CC_T0IF] = events.timer_zero_ovf;
    core_set[mief_pkg::CC_EXTIF] = events.ext_edge;
    core_set[mief_pkg::CC_PCIF] = events.port_change;
  end

  // peripheral flag set pulses, same layout as the enable register
  // shared positions keep each enable paired with its own flag
  logic [7:0] periph_set;
  always_comb begin
    periph_set = 8'h00;
    periph_set[mief_pkg::PF_AD] = events.ad_done;
    periph_set[mief_pkg::PF_CCP] = events.ccp;
    periph_set[mief_pkg::PF_TMR2] = events.tmr2_match;
    periph_set[mief_pkg::PF_TMR1] = events.tmr1_ovf;
  end

  // core flags live in the low three bits; writes may set or clear
  // them, a simultaneous event still wins so nothing is lost
  mief_flag_reg #(
    .W(8),
    .RST(mief_pkg::CORE_CTRL_RST)
  ) u_core_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(core_set),
    .wr_en(wr_cc),
    .wr_data(wbyte & CC_FLAG_BITS),
    .clr_en(1'b0),
    .clr_mask(8'h00),
    .q(core_flags_q)
  );

  // enable half of core control, plain storage; flags kept out so a
  // software write never fights the set path of the flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_en_q <= mief_pkg::CORE_CTRL_RST;
    end else if (wr_cc) begin
      core_en_q <= wbyte & CC_EN_BITS;
    end
  end

  // read view merges both halves, flag half masked to its three bits
  assign core_irq_control = core_en_q |
                            (core_flags_q & CC_FLAG_BITS);

  // peripheral enable, unimplemented bits dropped on write
  // positions never stored cannot read back as anything but zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enable <= mief_pkg::PERIPH_EN_RST;
    end else if (wr_pe) begin
      peripheral_irq_enable <=
        wbyte & mief_pkg::PERIPH_IMPL;
    end
  end

  // peripheral flags kept apart from enables; sticky until written low
  // a write stores the value, yet an event in the same cycle still wins
  mief_flag_reg #(
    .W(8),
    .RST(mief_pkg::PERIPH_FLAG_RST)
  ) u_periph_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(periph_set),
    .wr_en(wr_pf),
    .wr_data(wbyte & mief_pkg::PERIPH_IMPL),
    .clr_en(1'b0),
    .clr_mask(8'h00),
    .q(peripheral_irq_flags)
  );

  // event status is write-one-to-clear, mask is plain storage
  // status sees every source, unlike the grouped core request
  logic [6:0] status_q; // instance output, seven sources
  mief_flag_reg #(
    .W(7),
    .RST(mief_pkg::IRQ_STATUS_RST)
  ) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(events),
    .wr_en(1'b0),
    .wr_data(7'h00),
    .clr_en(wr_st),
    .clr_mask(wbyte[6:0]),
    .q(status_q)
  );
  assign irq_status = status_q;

  // event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= mief_pkg::IRQ_MASK_RST;
    end else if (wr_mk) begin
      irq_mask <= wbyte[6:0];
    end
  end

  // request to the core: global gate over core and peripheral terms
  // per-source peripheral view; one enable bit pairs with one flag
  logic [7:0] periph_armed; // enabled and flagged peripheral sources
  logic core_term; // enabled core sources
  logic periph_term; // enabled peripheral sources
  logic next_req; // next core request level
  assign periph_armed = peripheral_irq_enable & peripheral_irq_flags;
  always_comb begin
    core_term = armed(core_irq_control, mief_pkg::CC_T0IE,
                      mief_pkg::CC_T0IF) |
                armed(core_irq_control, mief_pkg::CC_EXTIE,
                      mief_pkg::CC_EXTIF) |
                armed(core_irq_control, mief_pkg::CC_PCIE,
                      mief_pkg::CC_PCIF);
    // conversion term is among these, gated by its own enable
    periph_term = (|periph_armed) &
                  core_irq_control[mief_pkg::CC_PERIPHERAL_GROUP_ENABLE];
    // global enable gates both groups; flags keep setting regardless
    next_req = core_irq_control[mief_pkg::CC_GIE] &
               (core_term | periph_term);
  end

  // one cycle of latency traded for a glitch-free level at the core
  // registered request so the core sees a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= next_req;
    end
  end

  // system interrupt from masked sticky status
  // lags status by one cycle, the same as the core request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // read strobe is unused: reads have no side effects here
  // upper write lanes and bytes are sunk here on purpose
  logic unused_rd;
  assign unused_rd = rd_stb | (|pstrb[3:1]) | (|pwdata[31:8]);
endmodule
`default_nettype wire

// ### hdl/mief_pkg.sv
package mief_pkg;

  // apb byte addresses: printed offsets 0Bh, 8Bh, 8Ch, 0Ch are not all
  // multiples of four, so each is an index and the byte address is 4x
  localparam logic [7:0] CORE_CTRL_IDX_LO = 8'h0b; // bank zero alias
  localparam logic [7:0] CORE_CTRL_IDX_HI = 8'h8b; // bank one alias
  localparam logic [7:0] PERIPH_EN_IDX = 8'h8c;
  localparam logic [7:0] PERIPH_FLAG_IDX = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h40; // sticky event status
  localparam logic [7:0] IRQ_MASK_IDX = 8'h41; // mask of status
  localparam int ADDR_W = 12;

  // core control field positions
  localparam int CC_GIE = 7;
  localparam int CC_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int CC_T0IE = 5;
  localparam int CC_EXTIE = 4;
  localparam int CC_PCIE = 3;
  localparam int CC_T0IF = 2;
  localparam int CC_EXTIF = 1;
  localparam int CC_PCIF = 0;

  // peripheral enable and flag positions (shared layout)
  localparam int PF_AD = 6;
  localparam int PF_CCP = 2;
  localparam int PF_TMR2 = 1;
  localparam int PF_TMR1 = 0;
  localparam logic [7:0] PERIPH_IMPL = 8'h47; // implemented bits

  // reset values
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [6:0] IRQ_STATUS_RST = 7'h00;
  localparam logic [6:0] IRQ_MASK_RST = 7'h00;

  // one pulse per source, same order as the status register
  typedef struct packed {
    logic ad_done;
    logic ccp;
    logic tmr2_match;
    logic tmr1_ovf;
    logic timer_zero_ovf;
    logic ext_edge;
    logic port_change;
  } mief_events_s;

  // apb request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } mief_apb_req_s;

endpackage

// ### hdl/mief_flag_reg.sv
`timescale 1ns/1ns
`default_nettype none
// one sticky flag bit per source: hardware set wins over software clear
module mief_flag_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set_in,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic clr_en,
  input wire logic [W-1:0] clr_mask,
  output logic [W-1:0] q
);
  logic [W-1:0] next_q; // next flag state

  // write, then write-one-clear, then set overrides both
  always_comb begin
    next_q = q;
    if (wr_en) begin
      next_q = wr_data;
    end
    if (clr_en) begin
      next_q = next_q & ~clr_mask;
    end
    next_q = next_q | set_in;
  end

  // flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/mief_apb_slave.sv
`timescale 1ns/1ns
`default_nettype none
// zero wait apb slave front: decode strobes, registered read data
module mief_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire mief_pkg::mief_apb_req_s req,
  input wire logic [31:0] rd_word,
  input wire logic rd_hit,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_stb,
  output logic rd_stb
);
  logic access; // access phase of any transfer
  logic unused_req; // address and data are decoded by the register file
  assign unused_req = ^{req.addr, req.wdata};

  assign access = req.sel & req.enable;
  assign pready = access; // always ready, no wait states
  assign wr_stb = access & req.write;
  assign rd_stb = access & ~req.write;
  // unmapped addresses answer with an error and no effect
  assign pslverr = access & ~rd_hit;

  // read data captured during setup so it is steady in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel & ~req.enable & ~req.write) begin
      prdata <= rd_hit ? rd_word : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ### bench/mief_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks; shadows track the enables that software writes
module mief_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mief_pkg::mief_events_s events,
  input wire logic core_irq_req,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access phase
  logic wr; // write that lands
  logic cc_a; // either core control alias
  logic hit; // mapped address
  logic [7:0] cc; // core control enables only
  logic [7:0] pe; // peripheral enables
  logic [6:0] mk; // status mask
  logic live; // some enabled path to the core
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign cc_a = paddr == 12'h02c || paddr == 12'h22c;
  assign hit = cc_a || paddr == 12'h230 || paddr == 12'h030
    || paddr == 12'h100 || paddr == 12'h104;
  assign live = cc[7] && (|cc[5:3] || cc[6] && |pe);
  // flags are set by hardware too, so only enables are shadowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc <= 8'h00;
      pe <= 8'h00;
      mk <= 7'h00;
    end else if (wr) begin
      if (cc_a)
        cc <= pwdata[7:0] & 8'hf8;
      if (paddr == 12'h230)
        pe <= pwdata[7:0] & 8'h47;
      if (paddr == 12'h104)
        mk <= pwdata[6:0];
    end
  end
  // event taken while armed, still armed one cycle later
  sequence t0_armed;
    events.timer_zero_ovf && cc[7] && cc[5] ##1 cc[7] && cc[5];
  endsequence
  sequence ad_armed;
    events.ad_done && cc[7] && cc[6] && pe[6] ##1 cc[7] && cc[6] && pe[6];
  endsequence
  access_ready_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped address");
  alias_read_a: assert property (acc && !pwrite && cc_a |->
    prdata[7:3] == cc[7:3]) else $error("core control read wrong");
  periph_en_read_a: assert property (acc && !pwrite &&
    paddr == 12'h230 |-> prdata == {24'h0, pe})
    else $error("peripheral enable read wrong");
  blocked_req_a: assert property (!live [*2] |-> !core_irq_req)
    else $error("request while every path disabled");
  timer_req_a: assert property (t0_armed |=> core_irq_req)
    else $error("no request after timer event");
  conv_req_a: assert property (ad_armed |=> core_irq_req)
    else $error("no request after conversion event");
  ccp_irq_a: assert property (events.ccp && mk[5] ##1 mk[5] |=> irq)
    else $error("no irq after capture event");
endmodule
bind mief_top mief_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .events(events), .core_irq_req(core_irq_req),
  .irq(irq));
`default_nettype wire

// ### bench/mief_event_src.sv
`timescale 1ns/1ns
`default_nettype none
// event sources: one-cycle pulses on request, low when idle
module mief_event_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] fire,
  output var mief_pkg::mief_events_s events
);
  // registered so pulses change just after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      events <= '0;
    else
      events <= mief_pkg::mief_events_s'(fire);
  end
endmodule
`default_nettype wire

// ### bench/test_mcu_interrupt_enable_flag_logic.sv
`timescale 1ns/1ns
`default_nettype none
// apb master plus event sources, expectations worked out here
module test_mcu_interrupt_enable_flag_logic;
  logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf; // byte lane zero always on
  logic pready, pslverr, core_irq_req, irq, er;
  logic [6:0] fire = 7'h00, m;
  logic [7:0] c, p;
  mief_pkg::mief_events_s events;
  int num_errors, n_compared, s;
  logic [11:0] regs [6] = '{12'h02c, 12'h22c, 12'h230, 12'h030,
    12'h100, 12'h104};
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  mief_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .core_irq_req(core_irq_req), .irq(irq));
  mief_event_src src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .events(events));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer; idle edge after it so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // pulse sources, then let flag and request settle
  task automatic kick(input logic [6:0] v);
    fire <= v;
    @(posedge pclk);
    fire <= 7'h00;
    repeat (4) @(posedge pclk);
  endtask
  // request expected for source sv under the given enables
  function automatic logic want(input logic [7:0] cv, pv, input int sv);
    logic [3:0] pm;
    pm = {pv[6], pv[2], pv[1], pv[0]};
    if (sv < 3)
      return cv[7] & cv[sv + 3];
    return cv[7] & cv[6] & pm[sv - 3];
  endfunction
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(81318));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (regs[i]) begin
      apb(1'h0, regs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'h0, 12'h3fc, 32'h0);
    chk("unmapped error", er, 1'h1);
    apb(1'h1, 12'h230, 32'hffffffff);
    apb(1'h0, 12'h230, 32'h0);
    chk("periph enable", rd, 32'h47);
    c = 8'($urandom);
    apb(1'h1, 12'h02c, {24'h0, c});
    apb(1'h0, 12'h22c, 32'h0);
    chk("alias", rd, {24'h0, c});
    apb(1'h1, 12'h02c, 32'h0);
    apb(1'h1, 12'h030, 32'h0);
    kick(7'h7f);
    chk("blocked req", core_irq_req, 1'h0);
    apb(1'h0, 12'h02c, 32'h0);
    chk("core flags", rd, 32'h7);
    apb(1'h0, 12'h030, 32'h0);
    chk("periph flags", rd, 32'h47);
    // first seven rounds walk every source fully enabled
    for (int i = 0; i < 40; i++) begin
      c = 8'($urandom) | (i < 7 ? 8'hff : 8'h0);
      p = 8'($urandom) | (i < 7 ? 8'hff : 8'h0);
      m = 7'($urandom) | (i < 7 ? 7'h7f : 7'h0);
      s = i < 7 ? i : $urandom_range(6, 0);
      apb(1'h1, 12'h02c, 32'h0);
      apb(1'h1, 12'h030, 32'h0);
      apb(1'h1, 12'h100, 32'h7f);
      apb(1'h1, 12'h104, {25'h0, m});
      apb(1'h1, 12'h230, {24'h0, p});
      apb(1'h1, 12'h02c, {24'h0, c[7:3], 3'h0});
      kick(7'h01 << s);
      chk("request", core_irq_req, want(c, p, s));
      chk("irq", irq, m[s]);
      apb(1'h1, 12'h100, 32'h1 << s);
      apb(1'h0, 12'h100, 32'h0);
      chk("status", rd, 32'h0);
    end
    tally_and_finish();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
